// >>> design/safe_output_test_sequencer.sv
/*
 * Safe output test sequencer: two-channel fail-safe output with periodic
 * test stop. Settings are plain ports, held stable by the outside.
 */
`timescale 1ns/1ps
`include "sotest_cfg.svh"
module safe_output_test_sequencer (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [14:0] status_in,
   input wire logic [7:0] internal_in,
   input wire logic [23:0] output_source_slots_in,
   input wire logic [63:0] test_interval_setting_in,
   input wire logic [15:0] test_start_sources_in,
   input wire logic [3:0] test_start_source_in,
   input wire logic [7:0] safe_state_mask_in,
   input wire logic test_enable_in,
   input wire logic [3:0] output_test_mode_in,
   input wire logic [3:0] feedback_input_enable_in,
   input wire logic [15:0] feedback_wait_time_in,
   input wire logic failsafe_input_in,
   input wire logic fault_ack_in,
   output logic channel_a_out,
   output logic channel_b_out,
   output logic safe_state_out,
   output logic test_busy_out,
   output logic test_due_out,
   output logic fault_out,
   output logic [63:0] remaining_out
);
   typedef struct packed {
      sotest_pkg::phase_type phase;
      logic [63:0] remain;
      logic [31:0] wait_cnt;
      logic start_prev;
      logic fault;
      logic expired;
      logic out_val;
      logic ch_a;
      logic ch_b;
      logic safe;
      logic busy;
   } state_type;
   state_type st_r, st_nxt;
   logic [5:0] used, val;
   logic comb_val, start, start_edge, fb_mode, fb_ok;
   logic [31:0] wait_cyc;
   logic [63:0] wait_wide;
   genvar g;
   generate
      for (g = 0; g < `SLOTS; g++) begin : g_slot
         slot_select u_slot (
            .sel_in(output_source_slots_in[g*4 +: 4]),
            .status_in(status_in),
            .used_out(used[g]),
            .value_out(val[g])
         );
      end
   endgenerate
   always_comb begin
      // unused slots ignored (read as 1 in the AND)
      comb_val = (|used) & (&val);
      // selectable start source, 0 = none
      start = (test_start_source_in != 4'h0) & test_start_sources_in[test_start_source_in];
      start_edge = start & ~st_r.start_prev;
      // modes 2,3 check feedback if an input is enabled
      fb_mode = ((output_test_mode_in == 4'h2) | (output_test_mode_in == 4'h3))
         & (|feedback_input_enable_in);
      // mode 2 expects feedback low when a channel is off, mode 3 high
      fb_ok = (output_test_mode_in == 4'h3) ? failsafe_input_in : ~failsafe_input_in;
      // configured wait in ms
      // long settings overflow 32 bits; saturate instead of wrapping short
      wait_wide = 64'(feedback_wait_time_in) * 64'(`CYC_PER_MS);
      if (wait_wide > 64'h00000000FFFFFFFF) begin
         wait_cyc = 32'hFFFFFFFF;
      end else begin
         wait_cyc = wait_wide[31:0];
      end
      if (wait_cyc < 32'(`WAIT_MIN_CYC)) begin
         wait_cyc = 32'(`WAIT_MIN_CYC);
      end
   end
   always_comb begin
      st_nxt = st_r;
      st_nxt.start_prev = start;
      st_nxt.out_val = comb_val;
      // safe state from masked internal signals
      st_nxt.safe = |(internal_in & safe_state_mask_in);
      if (st_r.remain != 64'h0) begin
         st_nxt.remain = st_r.remain - 64'h1;
      end else if (test_enable_in) begin
         st_nxt.expired = 1'b1;
      end
      if (start_edge) begin
         st_nxt.remain = test_interval_setting_in;
         st_nxt.expired = 1'b0;
      end
      st_nxt.wait_cnt = (st_r.wait_cnt != 32'h0) ? st_r.wait_cnt - 32'h1 : 32'h0;
      case (st_r.phase)
         sotest_pkg::ST_IDLE: begin
            if (start_edge & test_enable_in) begin
               st_nxt.phase = sotest_pkg::ST_A_OFF;
               st_nxt.wait_cnt = fb_mode ? wait_cyc : `PHASE_CYC;
            end
         end
         // sequential off, fixed dwell without feedback
         sotest_pkg::ST_A_OFF: begin
            if (fb_mode & fb_ok) begin
               st_nxt.phase = sotest_pkg::ST_A_WAIT;
               st_nxt.wait_cnt = `PHASE_CYC;
            end else if (st_r.wait_cnt == 32'h0) begin
               if (fb_mode) begin
                  st_nxt.phase = sotest_pkg::ST_FAULT;
               end else begin
                  st_nxt.phase = sotest_pkg::ST_A_WAIT;
                  st_nxt.wait_cnt = `PHASE_CYC;
               end
            end
         end
         sotest_pkg::ST_A_WAIT: begin
            if (st_r.wait_cnt == 32'h0) begin
               st_nxt.phase = sotest_pkg::ST_B_OFF;
               st_nxt.wait_cnt = fb_mode ? wait_cyc : `PHASE_CYC;
            end
         end
         sotest_pkg::ST_B_OFF: begin
            if (fb_mode & fb_ok) begin
               st_nxt.phase = sotest_pkg::ST_B_WAIT;
               st_nxt.wait_cnt = `PHASE_CYC;
            end else if (st_r.wait_cnt == 32'h0) begin
               if (fb_mode) begin
                  st_nxt.phase = sotest_pkg::ST_FAULT;
               end else begin
                  st_nxt.phase = sotest_pkg::ST_B_WAIT;
                  st_nxt.wait_cnt = `PHASE_CYC;
               end
            end
         end
         sotest_pkg::ST_B_WAIT: begin
            if (st_r.wait_cnt == 32'h0) begin
               st_nxt.phase = sotest_pkg::ST_IDLE;
            end
         end
         sotest_pkg::ST_FAULT: begin
            if (fault_ack_in & ~st_r.expired) begin
               st_nxt.phase = sotest_pkg::ST_IDLE;
            end
         end
         default: st_nxt.phase = sotest_pkg::ST_IDLE;
      endcase
      // fault latched; a new fault wins over the acknowledge
      if (st_nxt.phase == sotest_pkg::ST_FAULT | st_nxt.expired) begin
         st_nxt.fault = 1'b1;
      end else if (fault_ack_in) begin
         st_nxt.fault = 1'b0;
      end
      st_nxt.ch_a = comb_val & ~st_nxt.fault & (st_nxt.phase != sotest_pkg::ST_A_OFF)
         & (st_nxt.phase != sotest_pkg::ST_A_WAIT);
      st_nxt.ch_b = comb_val & ~st_nxt.fault & (st_nxt.phase != sotest_pkg::ST_B_OFF)
         & (st_nxt.phase != sotest_pkg::ST_B_WAIT);
      st_nxt.busy = (st_nxt.phase != sotest_pkg::ST_IDLE)
         & (st_nxt.phase != sotest_pkg::ST_FAULT);
      if (!rst_n_in) begin
         st_nxt = '0;
         st_nxt.phase = sotest_pkg::ST_IDLE;
         st_nxt.remain = `INTERVAL_DEF_CYC;
      end
   end
   always_ff @(posedge clock_in) begin
      st_r <= st_nxt;
   end
   always_comb begin
      channel_a_out = st_r.ch_a;
      channel_b_out = st_r.ch_b;
      safe_state_out = st_r.safe;
      test_busy_out = st_r.busy;
      test_due_out = st_r.expired;
      fault_out = st_r.fault;
      remaining_out = st_r.remain;
   end
   // defaults for mode/feedback are the outside's settings
   // wait exceeding actuator time is the outside's choice
endmodule // safe_output_test_sequencer

// >>> design/slot_select.sv
/*
 * One output source slot: selects one of fifteen status signals.
 * Code zero means the slot is not assigned.
 */
`timescale 1ns/1ps
`include "sotest_cfg.svh"
module slot_select (
   input wire logic [3:0] sel_in,
   input wire logic [14:0] status_in,
   output logic used_out,
   output logic value_out
);
   always_comb begin
      used_out = (sel_in != 4'h0);
      value_out = used_out ? status_in[sel_in - 4'h1] : 1'b1;
   end
endmodule // slot_select

// >>> design/sotest_cfg.svh
/*
 * Constants of the safe output test sequencer: reset values of the settings
 * and timing counts. Assumes a 100 MHz clock.
 */
// What this block does
// - periodically self-test output, supervise with timer
// - test interval configurable, default eight hours
// - test start reloads interval remaining time
// - six output source selectors, default zero
// - unassigned source slots ignored when combining
// - no slot assigned gives output low
// - safe state from bit mask, default 0000_0001
// - test mode setting, default binary 0100
// - feedback input enable, default 0000
// - modes 2,3 sequential off with feedback check
// - mode 4 sequential off, no feedback
// - feedback within wait time, default 500 ms
// - feedback wait never below 24 ms
`ifndef SOTEST_CFG_SVH
`define SOTEST_CFG_SVH
`define CLK_HZ 100000000
`define INTERVAL_S 28800
`define INTERVAL_DEF_CYC (`INTERVAL_S * 64'd100000000)
`define WAIT_DEF_MS 500
`define WAIT_MIN_MS 24
`define CYC_PER_MS (`CLK_HZ / 1000)
`define WAIT_MIN_CYC (`WAIT_MIN_MS * `CYC_PER_MS)
`define SLOTS 6
`define SEL_W 4
`define SEL_DEF 4'h0
`define MASK_DEF 8'h01
`define MODE_DEF 4'h4
`define FB_EN_DEF 4'h0
`define PHASE_CYC 32'h000F4240
`endif

// >>> design/sotest_pkg.sv
/*
 * Types of the safe output test sequencer. Assumes sotest_cfg.svh.
 */
package sotest_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_A_OFF, ST_A_WAIT, ST_B_OFF, ST_B_WAIT, ST_FAULT
   } phase_type;
endpackage

// >>> test/actuator_model.sv
/* actuator with feedback wiring
   assumes the bench clock; answers two cycles after the channels move */
`timescale 1ns/1ps
module actuator_model (
   input wire logic clock_in,
   input wire logic channel_a_in,
   input wire logic channel_b_in,
   input wire logic inverted_in,
   output logic feedback_out
);
   logic [1:0] lag_r;
   always_ff @(posedge clock_in) begin
      lag_r <= {lag_r[0], channel_a_in & channel_b_in};
   end
   assign feedback_out = lag_r[1] ^ inverted_in;
endmodule // actuator_model

// >>> test/safe_output_test_sequencer_test.sv
/* bench of the test sequencer: settings driven at the falling edge
   assumes the checker is bound and the actuator model sits on the channels */
`timescale 1ns/1ps
module safe_output_test_sequencer_test;
   logic clock_in = 1'b0, rst_n_in = 1'b0, en = 1'b0;
   logic [14:0] status = 15'h7FFF;
   logic [7:0] intl = 8'h01, mask = 8'h01;
   logic [23:0] slots = 24'h0;
   logic [63:0] ivl = 64'h0, rem;
   logic [15:0] srcs = 16'h0;
   logic [3:0] mode = 4'h4, fben = 4'h0;
   logic [3:0] mv [3] = '{4'h2, 4'h3, 4'h4};
   logic a, b, ss, busy, due, flt, fb;
   int failures = 0, check_count = 0, cyc = 0;
   safe_output_test_sequencer dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .status_in(status),
      .internal_in(intl), .output_source_slots_in(slots), .test_interval_setting_in(ivl),
      .test_start_sources_in(srcs), .test_start_source_in(4'h1), .safe_state_mask_in(mask),
      .test_enable_in(en), .output_test_mode_in(mode), .feedback_input_enable_in(fben),
      .feedback_wait_time_in(16'h01F4), .failsafe_input_in(fb), .fault_ack_in(1'b0),
      .channel_a_out(a), .channel_b_out(b), .safe_state_out(ss), .test_busy_out(busy),
      .test_due_out(due), .fault_out(flt), .remaining_out(rem));
   actuator_model fbm (.clock_in(clock_in), .channel_a_in(a), .channel_b_in(b),
      .inverted_in(mode == 4'h3), .feedback_out(fb));
   initial begin
      forever #5 clock_in = ~clock_in;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clock_in);
   endtask
   task automatic restart;
      rst_n_in = 1'b0;
      step(8);
      rst_n_in = 1'b1;
      step(1);
   endtask
   task automatic close_out;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // hang guard: whole run is under a thousand cycles
   always @(posedge clock_in) begin
      cyc++;
      if (cyc > 5000) begin
         failures++;
         close_out();
      end
   end
   initial begin
      restart();
      chk(rem, 64'h0000029E8D607FFF);
      chk(64'({a, b, busy, flt}), 64'h0);
      slots = 24'h000F01;
      step(2);
      chk(64'({a, b}), 64'h3);
      status = 15'h7FFE;
      step(2);
      chk(64'({a, b}), 64'h0);
      status = 15'h7FFF;
      intl = 8'h02;
      step(2);
      chk(64'(ss), 64'h0);
      mask = 8'h03;
      step(2);
      chk(64'(ss), 64'h1);
      $display("test combine done");
      ivl = 64'h28;
      // outside raises the selected start source
      srcs = 16'hFFFF;
      step(3);
      srcs = 16'h0;
      chk(64'(busy), 64'h0);
      chk(rem, 64'h26);
      en = 1'b1;
      step(50);
      chk(64'({due, flt, a, b}), 64'hC);
      $display("test expiry done");
      ivl = 64'h186A0;
      foreach (mv[i]) begin
         restart();
         mode = mv[i];
         fben = (mv[i] == 4'h4) ? 4'h0 : 4'h1;
         srcs = 16'hFFFF;
         step(2);
         chk(64'({busy, a, b}), 64'h5);
         step(200);
         chk(64'({busy, flt}), 64'h2);
         srcs = 16'h0;
      end
      $display("test modes done");
      close_out();
   end
endmodule // safe_output_test_sequencer_test

// >>> test/sotest_sva.sv
/* checker of the test sequencer ports
   assumes one clock, synchronous active-low reset, bound into every instance */
`timescale 1ns/1ps
module sotest_sva (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [7:0] internal_in,
   input wire logic [23:0] output_source_slots_in,
   input wire logic [63:0] test_interval_setting_in,
   input wire logic [15:0] test_start_sources_in,
   input wire logic [3:0] test_start_source_in,
   input wire logic [7:0] safe_state_mask_in,
   input wire logic test_enable_in,
   input wire logic channel_a_out,
   input wire logic channel_b_out,
   input wire logic safe_state_out,
   input wire logic test_busy_out,
   input wire logic test_due_out,
   input wire logic fault_out,
   input wire logic [63:0] remaining_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   sequence start_s;
      test_start_source_in != 4'h0 && $rose(test_start_sources_in[test_start_source_in]);
   endsequence
   sequence launch_s;
      start_s ##0 (test_enable_in && !test_busy_out && !fault_out);
   endsequence
   a_start_reload: assert property (start_s |=> remaining_out == $past(test_interval_setting_in))
      else $error("interval not reloaded at start");
   a_start_launch: assert property (launch_s |=> test_busy_out && !channel_a_out)
      else $error("start did not switch channel a off");
   a_b_stays: assert property (launch_s |=> channel_b_out == $past(channel_b_out))
      else $error("channel b moved with channel a");
   a_idle_disabled: assert property (!test_enable_in && !test_busy_out |=> !test_busy_out)
      else $error("test ran while disabled");
   a_no_source_low: assert property (output_source_slots_in == 24'h0 |=> !channel_a_out && !channel_b_out)
      else $error("output high with no source");
   a_safe_state: assert property (1'b1 |=> safe_state_out == |($past(internal_in) & $past(safe_state_mask_in)))
      else $error("safe state differs from mask");
   a_fault_off: assert property (fault_out && $past(fault_out) |-> !channel_a_out && !channel_b_out)
      else $error("output on during fault");
   a_due_fault: assert property (test_due_out && test_enable_in |-> ##[0:1] fault_out)
      else $error("expiry without fault");
endmodule // sotest_sva
bind safe_output_test_sequencer sotest_sva chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
   .internal_in(internal_in), .output_source_slots_in(output_source_slots_in),
   .test_interval_setting_in(test_interval_setting_in), .test_start_sources_in(test_start_sources_in),
   .test_start_source_in(test_start_source_in), .safe_state_mask_in(safe_state_mask_in),
   .test_enable_in(test_enable_in), .channel_a_out(channel_a_out), .channel_b_out(channel_b_out),
   .safe_state_out(safe_state_out), .test_busy_out(test_busy_out), .test_due_out(test_due_out),
   .fault_out(fault_out), .remaining_out(remaining_out));
